// ===== mpioc_core.sv
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mpioc_params.svh"

// Overview of operation
// - reset gives every pin to gpio
// - per-pin ownership set, clear, status
// - direction set, clear, status; gpio only
// - output level set, clear, status
// - gpio input undriven; function drives otherwise
// - pin level always readable
// - any pin edge sets change flag
// - enable/disable write shared interrupt mask
// - flag and mask raise shared interrupt
// - clear register write-one clears flags
// - without clear register, read clears flags
// - 32-bit registers, one bit per line
// - absent lines ignore writes, read zero
// - open drain drives low only
// - open drain set, clear, status, both owners
// - clock gate registers at 0x50..0x58
// - bit 0 io clock, bit 1 function
// - gated logic freezes, then resumes
// - interrupt logic runs while either clock on
// - every gpio line bidirectional
module mpioc_core
   import mpioc_pkg::*;
#(
   parameter bit HAS_CLEAR_REG = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire mpioc_line_t funcOut,
   input  wire mpioc_line_t funcOe,
   input  wire logic        funcIrq,
   output mpioc_line_t      funcIn,
   output logic      [1:0]  clkEnable,
   input  wire mpioc_line_t padIn,
   output mpioc_line_t      padOut,
   output mpioc_line_t      padOe,
   output logic             irq
);

   mpioc_state_s r;
   mpioc_state_s next_r;
   mpioc_ahb_s   ahb;
   mpioc_line_t  wd;
   mpioc_line_t  chgEdge;
   mpioc_line_t  drvOe;
   mpioc_line_t  drvVal;
   logic         ioRun;
   logic         funcRun;
   logic         irqRun;
   logic         wr;
   logic         rd;

   assign ahb = '{htrans: htrans, hwrite: hwrite, haddr: haddr[11:0],
                  hsel: hsel, hready: hready};
   assign wd = hwdata[7:0];
   assign ioRun = r.clkOn[`MPIOC_CLK_IO_BIT];
   assign funcRun = r.clkOn[`MPIOC_CLK_FUNC_BIT];
   assign irqRun = ioRun | funcRun;
   assign wr = r.dpValid & r.dpWrite;
   assign rd = ahb.hsel & ahb.htrans[1] & ahb.hready & ~ahb.hwrite;
   assign chgEdge = r.syncB ^ r.lastLevel;

   // per-line pad drive selection
   genvar gi;
   generate
      for (gi = 0; gi < `MPIOC_NUM_LINES; gi++) begin : gLine
         always_comb begin
            if (r.ownGpio[gi]) begin
               drvOe[gi] = r.dirOut[gi];
               drvVal[gi] = r.outLevel[gi];
            end else begin
               drvOe[gi] = funcOe[gi];
               drvVal[gi] = funcOut[gi];
            end
         end
      end
   endgenerate

   always_comb begin
      next_r = r;
      next_r.dpValid = ahb.hsel & ahb.htrans[1] & ahb.hready;
      next_r.dpWrite = ahb.hwrite;
      next_r.dpAddr = ahb.haddr;
      // pins sampled through two flops; second one feeds all logic
      next_r.syncA = padIn;
      next_r.syncB = r.syncA;
      if (wr) begin
         unique case (r.dpAddr)
            `MPIOC_OFS_CLK_ON:
               next_r.clkOn = r.clkOn | hwdata[1:0];
            `MPIOC_OFS_CLK_OFF:
               next_r.clkOn = r.clkOn & ~hwdata[1:0];
            `MPIOC_OFS_OD_SET:
               next_r.openDrain = r.openDrain | wd;
            `MPIOC_OFS_OD_CLEAR:
               next_r.openDrain = r.openDrain & ~wd;
            default: ;
         endcase
      end
      // io clock gating: frozen config keeps state
      if (wr && ioRun) begin
         unique case (r.dpAddr)
            `MPIOC_OFS_OWN_GPIO_SET:
               next_r.ownGpio = r.ownGpio | wd;
            `MPIOC_OFS_OWN_FUNC_SET:
               next_r.ownGpio = r.ownGpio & ~wd;
            `MPIOC_OFS_DIR_SET:
               next_r.dirOut = r.dirOut | wd;
            `MPIOC_OFS_DIR_CLEAR:
               next_r.dirOut = r.dirOut & ~wd;
            `MPIOC_OFS_LVL_SET:
               next_r.outLevel = r.outLevel | wd;
            `MPIOC_OFS_LVL_CLEAR:
               next_r.outLevel = r.outLevel & ~wd;
            default: ;
         endcase
      end
      if (irqRun) begin
         next_r.lastLevel = r.syncB;
         if (wr && r.dpAddr == `MPIOC_OFS_IRQ_SET)
            next_r.irqMask = r.irqMask | wd;
         if (wr && r.dpAddr == `MPIOC_OFS_IRQ_CLEAR)
            next_r.irqMask = r.irqMask & ~wd;
         if (HAS_CLEAR_REG && wr && r.dpAddr == `MPIOC_OFS_CHG_CLEAR)
            next_r.chgFlags = r.chgFlags & ~wd;
         // read clears at address phase; edges in the same cycle survive
         if (!HAS_CLEAR_REG && rd &&
             ahb.haddr == `MPIOC_OFS_CHG_FLAGS)
            next_r.chgFlags = '0;
         next_r.chgFlags = next_r.chgFlags | chgEdge;
      end
      next_r.irq = irqRun ? (|(r.chgFlags & r.irqMask) | funcIrq)
                          : r.irq;
      if (ioRun) begin
         for (int i = 0; i < `MPIOC_NUM_LINES; i++) begin
            if (r.openDrain[i]) begin
               next_r.padOut[i] = 1'b0;
               next_r.padOe[i] = drvOe[i] & ~drvVal[i];
            end else begin
               next_r.padOut[i] = drvVal[i];
               next_r.padOe[i] = drvOe[i];
            end
         end
      end
      next_r.rdata = '0;
      if (rd) begin
         unique case (ahb.haddr)
            `MPIOC_OFS_OWN_STATE: next_r.rdata[7:0] = r.ownGpio;
            `MPIOC_OFS_DIR_STATE: next_r.rdata[7:0] = r.dirOut;
            `MPIOC_OFS_LVL_STATE: next_r.rdata[7:0] = r.outLevel;
            `MPIOC_OFS_PIN_READ: next_r.rdata[7:0] = r.syncB;
            `MPIOC_OFS_IRQ_MASK: next_r.rdata[7:0] = r.irqMask;
            `MPIOC_OFS_CHG_FLAGS: next_r.rdata[7:0] = r.chgFlags;
            `MPIOC_OFS_OD_STATE: next_r.rdata[7:0] = r.openDrain;
            `MPIOC_OFS_CLK_STATE: next_r.rdata[1:0] = r.clkOn;
            default: next_r.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.ownGpio <= `MPIOC_RST_OWN;
         r.clkOn <= `MPIOC_RST_CLK;
         // idle pins rest at the pull-up level, so no false edge
         // follows reset; a pin held low still flags once
         r.syncA <= `MPIOC_RST_PIN;
         r.syncB <= `MPIOC_RST_PIN;
         r.lastLevel <= `MPIOC_RST_PIN;
      end else begin
         r <= next_r;
      end
   end

   // zero-wait slave; hrdata valid in the data phase cycle
   assign hrdata = r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign funcIn = r.syncB;
   assign clkEnable = r.clkOn;
   assign padOut = r.padOut;
   assign padOe = r.padOe;
   assign irq = r.irq;

endmodule

// ===== mpioc_params.svh
`ifndef MPIOC_PARAMS_SVH
`define MPIOC_PARAMS_SVH

`define MPIOC_NUM_LINES        8
`define MPIOC_LINE_MASK        32'h0000_00ff

`define MPIOC_OFS_OWN_GPIO_SET 12'h000
`define MPIOC_OFS_OWN_FUNC_SET 12'h004
`define MPIOC_OFS_OWN_STATE    12'h008
`define MPIOC_OFS_DIR_SET      12'h010
`define MPIOC_OFS_DIR_CLEAR    12'h014
`define MPIOC_OFS_DIR_STATE    12'h018
`define MPIOC_OFS_LVL_SET      12'h030
`define MPIOC_OFS_LVL_CLEAR    12'h034
`define MPIOC_OFS_LVL_STATE    12'h038
`define MPIOC_OFS_PIN_READ     12'h03c
`define MPIOC_OFS_IRQ_SET      12'h040
`define MPIOC_OFS_IRQ_CLEAR    12'h044
`define MPIOC_OFS_IRQ_MASK     12'h048
`define MPIOC_OFS_CHG_FLAGS    12'h04c
`define MPIOC_OFS_CLK_ON       12'h050
`define MPIOC_OFS_CLK_OFF      12'h054
`define MPIOC_OFS_CLK_STATE    12'h058
`define MPIOC_OFS_CHG_CLEAR    12'h05c
`define MPIOC_OFS_OD_SET       12'h060
`define MPIOC_OFS_OD_CLEAR     12'h064
`define MPIOC_OFS_OD_STATE     12'h068

`define MPIOC_CLK_IO_BIT       0
`define MPIOC_CLK_FUNC_BIT     1

`define MPIOC_RST_OWN          8'hff
`define MPIOC_RST_ZERO         8'h00
`define MPIOC_RST_CLK          2'h3
`define MPIOC_RST_PIN          8'hff

`endif

// ===== mpioc_pkg.sv
package mpioc_pkg;
   typedef logic [7:0] mpioc_line_t;

   typedef struct packed {
      logic [1:0]  htrans;
      logic        hwrite;
      logic [11:0] haddr;
      logic        hsel;
      logic        hready;
   } mpioc_ahb_s;

   typedef struct packed {
      logic        dpValid;
      logic        dpWrite;
      logic [11:0] dpAddr;
      mpioc_line_t ownGpio;
      mpioc_line_t dirOut;
      mpioc_line_t outLevel;
      mpioc_line_t openDrain;
      mpioc_line_t irqMask;
      mpioc_line_t chgFlags;
      logic [1:0]  clkOn;
      mpioc_line_t syncA;
      mpioc_line_t syncB;
      mpioc_line_t lastLevel;
      logic [31:0] rdata;
      mpioc_line_t padOut;
      mpioc_line_t padOe;
      logic        irq;
   } mpioc_state_s;
endpackage

// ===== mpioc_core_props.sv
`timescale 1ns/1ps
module mpioc_core_props
   import mpioc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        arst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire mpioc_line_t funcOut,
   input wire mpioc_line_t funcOe,
   input wire logic        funcIrq,
   input wire mpioc_line_t funcIn,
   input wire logic [1:0]  clkEnable,
   input wire mpioc_line_t padIn,
   input wire mpioc_line_t padOut,
   input wire mpioc_line_t padOe,
   input wire logic        irq
);
   wire wr = hsel && htrans[1] && hwrite;
   wire rq = hsel && htrans[1] && !hwrite;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("unused read bits set");
   a_func_irq: assert property (funcIrq && clkEnable != 2'h0 |=> irq)
      else $error("shared irq missing");
   a_irq_frozen: assert property (clkEnable == 2'h0 |=> $stable(irq))
      else $error("irq moved while gated");
   a_pin_follow: assert property ($stable(padIn)[*4] |-> funcIn == padIn)
      else $error("pin level not passed on");
   a_clk_by_write: assert property ($changed(clkEnable) |->
      $past(wr && haddr[11:4] == 8'h05, 2)) else $error("clock gate moved");
   a_pad_cause: assert property ($changed({padOut, padOe}) |->
      $past($changed({funcOut, funcOe})) || $past(wr, 2) || $past(wr, 3))
      else $error("pad drive changed alone");
   a_irq_drop: assert property ($fell(irq) |->
      $past($fell(funcIrq)) || $past(wr, 2) || $past(wr, 3) ||
      $past(rq, 2))
      else $error("irq dropped alone");
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (clkEnable == 2'h0);
endmodule

// ===== mpioc_pads.sv
`timescale 1ns/1ps
module mpioc_pads
   import mpioc_pkg::*;
(
   input  wire mpioc_line_t padOut,
   input  wire mpioc_line_t padOe,
   input  wire mpioc_line_t extOe,
   input  wire mpioc_line_t extVal,
   output mpioc_line_t      padIn
);
   // device wins a fight; released lines float to the pull-up
   assign padIn = (padOe & padOut) | (~padOe & (~extOe | extVal));
endmodule

// ===== tb_muxed_pin_io_controller.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin failures++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
module tb_muxed_pin_io_controller;
   import mpioc_pkg::*;
   logic        ref_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, funcIrq = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, hrd2, q, q2, d;
   logic [1:0]  htrans = 0, clkEnable;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, irq;
   wire logic   hready = hreadyout;
   mpioc_line_t funcOut = 0, funcOe = 0, extOe = 0, extVal = 0;
   mpioc_line_t funcIn, padIn, padOut, padOe;
   mpioc_line_t ex [5] = '{8'hff, 8'h0, 8'h0, 8'h0, 8'h0};
   logic [11:0] so [5] = '{12'h000, 12'h010, 12'h030, 12'h060, 12'h040};
   int          failures = 0, checked = 0, seed = 58017, k;
   always #2 ref_clk = ~ref_clk;
   mpioc_core DUT (.*);
   // second copy without a clear register: reads clear its flags
   mpioc_core #(.HAS_CLEAR_REG(1'b0)) DUT2 (
      .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrd2), .hreadyout(), .hresp(),
      .funcOut(funcOut), .funcOe(funcOe), .funcIrq(funcIrq), .funcIn(),
      .clkEnable(), .padIn(padIn), .padOut(), .padOe(), .irq());
   mpioc_pads board (.*);
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] v);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= v;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
      q2 = hrd2;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input string n);
      bus(1'b0, a, 32'h0);
      `CHK(n, e, q)
   endtask
   // expected pin level from the register model and board drive
   function automatic mpioc_line_t lvl();
      mpioc_line_t oe, v;
      oe = (ex[0] & ex[1]) | (~ex[0] & funcOe);
      v = (ex[0] & ex[2]) | (~ex[0] & funcOut);
      oe = oe & ~(ex[3] & v);
      v = v & ~ex[3];
      return (oe & v) | (~oe & (~extOe | extVal));
   endfunction
   task end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      end_sim;
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd(12'h008, 32'hff, "own");
      rd(12'h018, 32'h0, "dir");
      rd(12'h058, 32'h3, "clk");
      bus(1'b1, 12'h070, '1);
      rd(12'h070, 32'h0, "hole");
      for (int i = 0; i < 40; i++) begin
         k = {$random(seed)} % 5;
         d = $random(seed);
         bus(1'b1, so[k], d);
         ex[k] |= d[7:0];
         d = $random(seed);
         bus(1'b1, so[k] + 12'h4, d);
         ex[k] &= ~d[7:0];
         rd(so[k] + 12'h8, {24'h0, ex[k]}, "state");
         {funcOut, funcOe, extOe, extVal} <= $random(seed);
         repeat (8) @(posedge ref_clk);
         rd(12'h03c, {24'h0, lvl()}, "pins");
      end
      bus(1'b1, 12'h000, 32'h80);
      bus(1'b1, 12'h014, 32'h80);
      extOe <= 8'h80;
      repeat (8) @(posedge ref_clk);
      bus(1'b1, 12'h05c, '1);
      bus(1'b1, 12'h040, '1);
      rd(12'h04c, 32'h0, "flags");
      extVal[7] <= ~extVal[7];
      repeat (6) @(posedge ref_clk);
      rd(12'h04c, 32'h80, "flags");
      `CHK("flags2", 32'h80, q2)
      `CHK("irq", 1'b1, irq)
      bus(1'b1, 12'h044, 32'h80);
      repeat (3) @(posedge ref_clk);
      `CHK("irq", 1'b0, irq)
      funcIrq <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK("irq", 1'b1, irq)
      funcIrq <= 1'b0;
      bus(1'b1, 12'h05c, 32'h80);
      bus(1'b1, 12'h054, 32'h3);
      rd(12'h058, 32'h0, "clk");
      extVal[7] <= ~extVal[7];
      repeat (6) @(posedge ref_clk);
      rd(12'h04c, 32'h0, "flags");
      `CHK("flags2", 32'h0, q2)
      bus(1'b1, 12'h050, 32'h1);
      rd(12'h058, 32'h1, "clk");
      repeat (4) @(posedge ref_clk);
      rd(12'h04c, 32'h80, "flags");
      `CHK("flags2", 32'h80, q2)
      rd(12'h04c, 32'h80, "flags");
      `CHK("flags2", 32'h0, q2)
      bus(1'b1, 12'h050, 32'h2);
      rd(12'h058, 32'h3, "clk");
      end_sim;
   end
endmodule
bind mpioc_core mpioc_core_props props (.*);
